// ==== timer_pin_io_params.svh ====
// Purpose: offsets, field positions and reset values for the pin I/O control
// Assumes: included by its bare name
// Notes: byte addresses on a 32-bit Avalon-MM slave, data in the low byte
`ifndef TIMER_PIN_IO_PARAMS_SVH
`define TIMER_PIN_IO_PARAMS_SVH

`define OFS_IO_CTRL_CH1 4'h0
`define OFS_IO_CTRL_CH2 4'h4
`define OFS_IO_CTRL_CH3_HIGH 4'h8
`define OFS_IO_CTRL_CH3_LOW 4'hc
`define IO_CTRL_RESET 8'h00
`define HI_NIBBLE_MSB 7
`define HI_NIBBLE_LSB 4
`define LO_NIBBLE_MSB 3
`define LO_NIBBLE_LSB 0
`define FUNC_ROLE_BIT 3
`define FUNC_INIT_BIT 2
`define FUNC_BOTH_BIT 1
`define FUNC_FALL_BIT 0
`define OC_DISABLED 2'h0
`define OC_DRIVE_LOW 2'h1
`define OC_DRIVE_HIGH 2'h2
`define OC_TOGGLE 2'h3
`define CLK_SEL_UNDIVIDED 3'h0
`define NUM_UNITS 5

`endif

// ==== timer_pin_io_pkg.sv ====
// Purpose: shared types of the pin I/O control
// Assumes: nothing
// Notes: constants live in timer_pin_io_params.svh
package timer_pin_io_pkg;
	typedef logic [3:0] func_code_t;
	typedef logic [7:0] io_reg_t;
	typedef enum logic [1:0] {
		LINK_NONE,
		LINK_CH0_THIRD,
		LINK_CH4_COUNT
	} link_kind_e;
endpackage

// ==== tgr_channel.sv ====
// Purpose: one compare/capture register's pin role, decoded from a 4-bit code
// Assumes: pin and match inputs synchronous to mclk
// Notes: capture is a one-cycle strobe one edge after its cause
`timescale 1ns/1ps
`include "timer_pin_io_params.svh"
module tgr_channel #(
	parameter bit LINK_ENABLE = 1'b0,
	parameter bit BIT6_IGNORED = 1'b0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire timer_pin_io_pkg::func_code_t func_code,
	input wire logic code_written,
	input wire logic blocked,
	input wire logic cmp_match,
	input wire logic pin_in,
	input wire logic link_event,
	output logic pin_out_q,
	output logic pin_oe_n_q,
	output logic capture_q
);
	generate
		if (LINK_ENABLE && BIT6_IGNORED) begin : g_bad
			$error("a unit with a linked source cannot ignore the init bit");
		end
	endgenerate

	logic pin_prev_q;
	logic oc_mode;
	logic [1:0] oc_act;
	logic rise;
	logic fall;
	logic cap_d;

	assign oc_mode = !func_code[`FUNC_ROLE_BIT];
	assign oc_act = func_code[1:0];
	assign rise = pin_in && !pin_prev_q;
	assign fall = !pin_in && pin_prev_q;

	always_comb begin
		cap_d = 1'b0;
		if (blocked || oc_mode) begin
			cap_d = 1'b0;
		end else if (LINK_ENABLE && func_code[`FUNC_INIT_BIT]) begin
			cap_d = link_event;
		end else if (func_code[`FUNC_BOTH_BIT]) begin
			cap_d = rise || fall;
		end else if (func_code[`FUNC_FALL_BIT]) begin
			cap_d = fall;
		end else begin
			cap_d = rise;
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_in;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_oe_n_q <= 1'b1;
		end else begin
			pin_oe_n_q <= blocked || !oc_mode || oc_act == `OC_DISABLED;
		end
	end

	// a fresh write wins over a match in the same cycle so the initial
	// level is seen for at least one cycle, except while blocked, when the write is ignored
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_out_q <= 1'b0;
		end else if (blocked || !oc_mode) begin
			pin_out_q <= pin_out_q;
		end else if (code_written) begin
			pin_out_q <= func_code[`FUNC_INIT_BIT];
		end else if (cmp_match) begin
			case (oc_act)
				`OC_DRIVE_LOW: pin_out_q <= 1'b0;
				`OC_DRIVE_HIGH: pin_out_q <= 1'b1;
				`OC_TOGGLE: pin_out_q <= !pin_out_q;
				default: pin_out_q <= pin_out_q;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			capture_q <= 1'b0;
		end else begin
			capture_q <= cap_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	oc_init_a: assert property (@(posedge mclk) disable iff (rst)
		code_written && oc_mode && oc_act != `OC_DISABLED && !blocked
		|=> pin_out_q == $past(func_code[`FUNC_INIT_BIT]))
		else $error("initial level not applied on write");
	oc_low_a: assert property (@(posedge mclk) disable iff (rst)
		!code_written && oc_mode && oc_act == `OC_DRIVE_LOW && cmp_match
		&& !blocked |=> !pin_out_q)
		else $error("pin not low after match");
	oc_high_a: assert property (@(posedge mclk) disable iff (rst)
		!code_written && oc_mode && oc_act == `OC_DRIVE_HIGH && cmp_match
		&& !blocked |=> pin_out_q)
		else $error("pin not high after match");
	oc_toggle_a: assert property (@(posedge mclk) disable iff (rst)
		!code_written && oc_mode && oc_act == `OC_TOGGLE && cmp_match
		&& !blocked ##1 1'b1 |-> pin_out_q != $past(pin_out_q))
		else $error("pin not toggled on match");
	oc_off_a: assert property (@(posedge mclk) disable iff (rst)
		oc_mode && oc_act == `OC_DISABLED |=> pin_oe_n_q)
		else $error("pin driven while output disabled");
	cap_rise_a: assert property (@(posedge mclk) disable iff (rst)
		!oc_mode && !blocked && func_code[1:0] == 2'h0
		&& (BIT6_IGNORED || !func_code[`FUNC_INIT_BIT])
		|-> ##1 capture_q == $past(rise))
		else $error("rising capture wrong");
	cap_fall_a: assert property (@(posedge mclk) disable iff (rst)
		!oc_mode && !blocked && func_code[1:0] == 2'h1
		&& (!LINK_ENABLE || !func_code[`FUNC_INIT_BIT])
		|=> capture_q == $past(fall))
		else $error("falling capture wrong");
	cap_both_a: assert property (@(posedge mclk) disable iff (rst)
		!oc_mode && !blocked && func_code[`FUNC_BOTH_BIT]
		&& (!LINK_ENABLE || !func_code[`FUNC_INIT_BIT])
		&& pin_in != pin_prev_q |=> capture_q)
		else $error("edge capture missed");
	cap_link_a: assert property (@(posedge mclk) disable iff (rst)
		LINK_ENABLE && !oc_mode && !blocked && func_code[`FUNC_INIT_BIT]
		|=> capture_q == $past(link_event))
		else $error("linked capture wrong");
	buf_block_a: assert property (@(posedge mclk) disable iff (rst)
		blocked |=> !capture_q && pin_oe_n_q)
		else $error("activity while used as buffer");

	toggle_c: cover property (@(posedge mclk) disable iff (rst)
		oc_mode && oc_act == `OC_TOGGLE && cmp_match ##1 !pin_oe_n_q);
	capture_c: cover property (@(posedge mclk) disable iff (rst)
		capture_q);
	link_c: cover property (@(posedge mclk) disable iff (rst)
		LINK_ENABLE && link_event && func_code == 4'hc);
endmodule

// ==== timer_pin_io_control.sv ====
// Purpose: pin I/O control for compare/capture registers of channels 1 to 3
// Assumes: Avalon-MM slave, one wait state; all inputs synchronous to mclk
// Notes: unit order 0 ch1 second, 1 ch2 second, 2 ch3 second,
//        3 ch3 third, 4 ch3 fourth
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "timer_pin_io_params.svh"
module timer_pin_io_control #(
	parameter int ADDR_W = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [`NUM_UNITS-1:0] cmp_match,
	input wire logic [`NUM_UNITS-1:0] pin_in,
	input wire logic ch0_third_event,
	input wire logic ch4_count_pulse,
	input wire logic [2:0] ch4_clock_select,
	input wire logic buffer_mode_second_pair,
	output logic [`NUM_UNITS-1:0] pin_out,
	output logic [`NUM_UNITS-1:0] pin_oe_n,
	output logic [`NUM_UNITS-1:0] capture
);
	generate
		if (ADDR_W < 4) begin : g_bad_addr
			$error("ADDR_W must cover four word registers");
		end
	endgenerate

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	timer_pin_io_pkg::io_reg_t io_control_ch1_q;
	timer_pin_io_pkg::io_reg_t io_control_ch2_q;
	timer_pin_io_pkg::io_reg_t io_control_ch3_high_q;
	timer_pin_io_pkg::io_reg_t io_control_ch3_low_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic access_go;
	logic write_go;
	logic [3:0] word_addr;
	logic [`NUM_UNITS-1:0] written;
	logic [`NUM_UNITS-1:0] written_q;
	timer_pin_io_pkg::func_code_t func_code [`NUM_UNITS];
	logic [`NUM_UNITS-1:0] blocked;
	logic [`NUM_UNITS-1:0] link_event;
	logic ch4_count_ok;
	timer_pin_io_pkg::io_reg_t rsel;

	assign word_addr = address[3:0];
	// the answer comes on the second edge of a request; the write lands
	// on that edge, read data was loaded on the first
	assign access_go = (read || write) && !wait_q;
	assign write_go = write && !wait_q && byteenable[0];
	assign waitrequest = wait_q;
	assign readdata = rdata_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_q <= 1'b1;
		end else if ((read || write) && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	always_comb begin
		if (word_addr == `OFS_IO_CTRL_CH1) begin
			rsel = io_control_ch1_q;
		end else if (word_addr == `OFS_IO_CTRL_CH2) begin
			rsel = io_control_ch2_q;
		end else if (word_addr == `OFS_IO_CTRL_CH3_HIGH) begin
			rsel = io_control_ch3_high_q;
		end else if (word_addr == `OFS_IO_CTRL_CH3_LOW) begin
			rsel = io_control_ch3_low_q;
		end else begin
			rsel = 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (read && wait_q) begin
			rdata_q <= {24'h00_0000, rsel};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			io_control_ch1_q <= `IO_CTRL_RESET;
			io_control_ch2_q <= `IO_CTRL_RESET;
			io_control_ch3_high_q <= `IO_CTRL_RESET;
			io_control_ch3_low_q <= `IO_CTRL_RESET;
		end else if (write_go) begin
			if (word_addr == `OFS_IO_CTRL_CH1) begin
				io_control_ch1_q <= writedata[7:0];
			end else if (word_addr == `OFS_IO_CTRL_CH2) begin
				io_control_ch2_q <= writedata[7:0];
			end else if (word_addr == `OFS_IO_CTRL_CH3_HIGH) begin
				io_control_ch3_high_q <= writedata[7:0];
			end else if (word_addr == `OFS_IO_CTRL_CH3_LOW) begin
				io_control_ch3_low_q <= writedata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// unit mapping
	// ----------------------------------------------------------------
	assign func_code[0] = io_control_ch1_q[`HI_NIBBLE_MSB:`HI_NIBBLE_LSB];
	assign func_code[1] = io_control_ch2_q[`HI_NIBBLE_MSB:`HI_NIBBLE_LSB];
	assign func_code[2] =
		io_control_ch3_high_q[`HI_NIBBLE_MSB:`HI_NIBBLE_LSB];
	assign func_code[3] =
		io_control_ch3_low_q[`LO_NIBBLE_MSB:`LO_NIBBLE_LSB];
	assign func_code[4] =
		io_control_ch3_low_q[`HI_NIBBLE_MSB:`HI_NIBBLE_LSB];

	assign written[0] = write_go && word_addr == `OFS_IO_CTRL_CH1;
	assign written[1] = write_go && word_addr == `OFS_IO_CTRL_CH2;
	assign written[2] = write_go && word_addr == `OFS_IO_CTRL_CH3_HIGH;
	assign written[3] = write_go && word_addr == `OFS_IO_CTRL_CH3_LOW;
	assign written[4] = written[3];

	// the units see the write one edge after it lands, when the new code
	// already stands, so the initial level comes from the new code
	always_ff @(posedge mclk) begin
		if (rst) begin
			written_q <= {`NUM_UNITS{1'b0}};
		end else begin
			written_q <= written;
		end
	end

	// a count on the undivided clock is not a valid capture source
	assign ch4_count_ok = ch4_count_pulse
		&& ch4_clock_select != `CLK_SEL_UNDIVIDED;

	assign link_event[0] = ch0_third_event;
	assign link_event[1] = 1'b0;
	assign link_event[2] = ch4_count_ok;
	assign link_event[3] = ch4_count_ok;
	assign link_event[4] = ch4_count_ok;

	assign blocked[3:0] = 4'h0;
	assign blocked[4] = buffer_mode_second_pair;

	genvar u;
	generate
		for (u = 0; u < `NUM_UNITS; u++) begin : g_unit
			tgr_channel #(
				.LINK_ENABLE(u != 1),
				.BIT6_IGNORED(u == 1)
			) u_chan (
				.mclk(mclk),
				.rst(rst),
				.func_code(func_code[u]),
				.code_written(written_q[u]),
				.blocked(blocked[u]),
				.cmp_match(cmp_match[u]),
				.pin_in(pin_in[u]),
				.link_event(link_event[u]),
				.pin_out_q(pin_out[u]),
				.pin_oe_n_q(pin_oe_n[u]),
				.capture_q(capture[u])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	undiv_block_a: assert property (@(posedge mclk) disable iff (rst)
		ch4_clock_select == `CLK_SEL_UNDIVIDED && func_code[2] == 4'hc
		|=> !capture[2])
		else $error("capture from undivided channel 4 count");
	third_map_a: assert property (@(posedge mclk) disable iff (rst)
		write_go && word_addr == `OFS_IO_CTRL_CH3_LOW
		|=> func_code[3] == $past(writedata[3:0]))
		else $error("third register code not from low nibble");
	bus_answer_a: assert property (@(posedge mclk) disable iff (rst)
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one wait state");
	bus_write_c: cover property (@(posedge mclk) disable iff (rst)
		access_go && write);

	// ----------------------------------------------------------------
	// register file checks
	// ----------------------------------------------------------------
	reset_state_a: assert property (@(posedge mclk)
		rst |=> waitrequest && readdata == 32'h0000_0000
		&& capture == {`NUM_UNITS{1'b0}})
		else $error("bus or capture outputs not at reset values");
	reset_pins_a: assert property (@(posedge mclk)
		rst |=> pin_oe_n == {`NUM_UNITS{1'b1}}
		&& pin_out == {`NUM_UNITS{1'b0}})
		else $error("pins not released by reset");
	read_ch1_a: assert property (@(posedge mclk) disable iff (rst)
		read && waitrequest && word_addr == `OFS_IO_CTRL_CH1
		|=> readdata == {24'h00_0000, io_control_ch1_q})
		else $error("wrong read data for channel 1");
	read_ch2_a: assert property (@(posedge mclk) disable iff (rst)
		read && waitrequest && word_addr == `OFS_IO_CTRL_CH2
		|=> readdata == {24'h00_0000, io_control_ch2_q})
		else $error("wrong read data for channel 2");
	read_ch3_high_a: assert property (@(posedge mclk) disable iff (rst)
		read && waitrequest && word_addr == `OFS_IO_CTRL_CH3_HIGH
		|=> readdata == {24'h00_0000, io_control_ch3_high_q})
		else $error("wrong read data for channel 3 high");
	read_ch3_low_a: assert property (@(posedge mclk) disable iff (rst)
		read && waitrequest && word_addr == `OFS_IO_CTRL_CH3_LOW
		|=> readdata == {24'h00_0000, io_control_ch3_low_q})
		else $error("wrong read data for channel 3 low");
	// an unmapped offset answers like any other, with zero data
	read_unmapped_a: assert property (@(posedge mclk) disable iff (rst)
		read && waitrequest && word_addr != `OFS_IO_CTRL_CH1
		&& word_addr != `OFS_IO_CTRL_CH2
		&& word_addr != `OFS_IO_CTRL_CH3_HIGH
		&& word_addr != `OFS_IO_CTRL_CH3_LOW
		|=> readdata == 32'h0000_0000)
		else $error("unmapped offset read not zero");
	read_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!(read && waitrequest) |=> $stable(readdata))
		else $error("read data changed without a read");
	write_ch1_a: assert property (@(posedge mclk) disable iff (rst)
		write && !waitrequest && byteenable[0]
		&& word_addr == `OFS_IO_CTRL_CH1
		|=> io_control_ch1_q == $past(writedata[7:0]))
		else $error("channel 1 register write lost");
	write_ch2_a: assert property (@(posedge mclk) disable iff (rst)
		write && !waitrequest && byteenable[0]
		&& word_addr == `OFS_IO_CTRL_CH2
		|=> io_control_ch2_q == $past(writedata[7:0]))
		else $error("channel 2 register write lost");
	write_ch3_high_a: assert property (@(posedge mclk) disable iff (rst)
		write && !waitrequest && byteenable[0]
		&& word_addr == `OFS_IO_CTRL_CH3_HIGH
		|=> io_control_ch3_high_q == $past(writedata[7:0]))
		else $error("channel 3 high register write lost");
	write_ch3_low_a: assert property (@(posedge mclk) disable iff (rst)
		write && !waitrequest && byteenable[0]
		&& word_addr == `OFS_IO_CTRL_CH3_LOW
		|=> io_control_ch3_low_q == $past(writedata[7:0]))
		else $error("channel 3 low register write lost");
	// a write with byte lane 0 off is answered but changes nothing
	write_drop_a: assert property (@(posedge mclk) disable iff (rst)
		!write_go |=> $stable(io_control_ch1_q)
		&& $stable(io_control_ch2_q)
		&& $stable(io_control_ch3_high_q)
		&& $stable(io_control_ch3_low_q))
		else $error("register changed without an accepted write");
	fourth_map_a: assert property (@(posedge mclk) disable iff (rst)
		write_go && word_addr == `OFS_IO_CTRL_CH3_LOW
		|=> func_code[4] == $past(writedata[7:4]))
		else $error("fourth register code not from high nibble");

	// ----------------------------------------------------------------
	// unit mapping checks
	// ----------------------------------------------------------------
	link_ch1_a: assert property (@(posedge mclk) disable iff (rst)
		func_code[0][`FUNC_ROLE_BIT] && func_code[0][`FUNC_INIT_BIT]
		|=> capture[0] == $past(ch0_third_event))
		else $error("channel 1 linked capture wrong");
	link_ch3_second_a: assert property (@(posedge mclk)
		disable iff (rst)
		func_code[2][`FUNC_ROLE_BIT] && func_code[2][`FUNC_INIT_BIT]
		|=> capture[2] == $past(ch4_count_pulse
		&& ch4_clock_select != `CLK_SEL_UNDIVIDED))
		else $error("channel 3 second register linked capture wrong");
	link_ch3_fourth_a: assert property (@(posedge mclk)
		disable iff (rst)
		func_code[4][`FUNC_ROLE_BIT] && func_code[4][`FUNC_INIT_BIT]
		&& !buffer_mode_second_pair
		|=> capture[4] == $past(ch4_count_pulse
		&& ch4_clock_select != `CLK_SEL_UNDIVIDED))
		else $error("channel 3 fourth register linked capture wrong");
	generate
		for (u = 0; u < `NUM_UNITS; u++) begin : g_unit_chk
			oe_drive_a: assert property (@(posedge mclk) disable iff (rst)
				!func_code[u][`FUNC_ROLE_BIT] && !blocked[u]
				&& func_code[u][1:0] != `OC_DISABLED |=> !pin_oe_n[u])
				else $error("enabled output compare not driving");
			cap_release_a: assert property (@(posedge mclk) disable iff (rst)
				func_code[u][`FUNC_ROLE_BIT] |=> pin_oe_n[u])
				else $error("pin driven under a capture code");
			oc_no_cap_a: assert property (@(posedge mclk) disable iff (rst)
				!func_code[u][`FUNC_ROLE_BIT] |=> !capture[u])
				else $error("capture under an output compare code");
			// a capture code or buffer use freezes the driven level
			pin_hold_a: assert property (@(posedge mclk) disable iff (rst)
				blocked[u] || func_code[u][`FUNC_ROLE_BIT]
				|=> $stable(pin_out[u]))
				else $error("pin level moved while not comparing");
		end
	endgenerate
endmodule

// ==== timer_pin_partner.sv ====
// Purpose: far side of the timer pins, one shared wire per unit
// Assumes: no pull resistor on the pins
// Notes: drives its own level only while the block has released the pin
`timescale 1ns/1ps
module timer_pin_partner (
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe_n,
	input wire logic [4:0] ext_level,
	output logic [4:0] pin_level
);
	// ----------------------------------------
	// wire resolution
	// ----------------------------------------
	// the block wins while it drives; contention is not modelled
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pin_level[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
		end
	end
endmodule

// ==== test_timer_pin_io_control.sv ====
// Purpose: self-checking bench for the pin I/O control
// Assumes: one wait state on the register bus, unit order as in the block
// Notes: capture strobes are matched against a queue of expected vectors
`timescale 1ns/1ps
module test_timer_pin_io_control;
	logic mclk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
	logic [3:0] address = 4'h0, byteenable = 4'h0;
	logic [31:0] writedata = 32'h0, readdata, seed = 32'h2f;
	logic waitrequest, ch0_third_event = 1'b0, ch4_count_pulse = 1'b0;
	logic [2:0] ch4_clock_select = 3'h1;
	logic buffer_mode_second_pair = 1'b0;
	logic [4:0] cmp_match = 5'h00, ext_level = 5'h00, pin_in;
	logic [4:0] pin_out, pin_oe_n, capture, q_head;
	logic [4:0] exp_q[$];
	logic [7:0] sh[4];
	int n_errors = 0, checked = 0;
	timer_pin_io_control dut (.mclk(mclk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .cmp_match(cmp_match), .pin_in(pin_in),
		.ch0_third_event(ch0_third_event), .ch4_count_pulse(ch4_count_pulse),
		.ch4_clock_select(ch4_clock_select),
		.buffer_mode_second_pair(buffer_mode_second_pair),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .capture(capture));
	timer_pin_partner far_side (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_level(ext_level), .pin_level(pin_in));
	// ----------------------------------------
	// clock, helpers
	// ----------------------------------------
	initial begin
		forever #4 mclk = ~mclk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one request, held until waitrequest is sampled low
	task automatic bus(input logic rd, input logic [3:0] a,
		input logic [7:0] d, input logic be, input logic [7:0] exp);
		int n;
		@(posedge mclk);
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= {3'h0, be};
		read <= rd;
		write <= !rd;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (rd) chk(readdata, {24'h0, exp});
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 20) begin
			n_errors++;
			give_verdict();
		end
	endtask
	task automatic set_code(input int u, input logic [3:0] c);
		int r;
		r = (u < 3) ? u : 3;
		if (u == 3) sh[3][3:0] = c;
		else sh[r][7:4] = c;
		bus(1'b0, 4'(r * 4), sh[r], 1'b1, 8'h00);
	endtask
	// ----------------------------------------
	// capture monitor
	// ----------------------------------------
	always @(posedge mclk) begin
		#1;
		if (!rst && capture !== 5'h00) begin
			q_head = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h00;
			chk(capture, q_head);
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] b;
		logic lv, ex;
		logic [3:0] cd;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk(pin_oe_n, 5'h1f);
		chk(pin_out, 5'h00);
		chk(waitrequest, 1'b1);
		for (int r = 0; r < 4; r++) bus(1'b1, 4'(r * 4), 8'h00, 1'b1, 8'h00);
		for (int r = 0; r < 4; r++) begin
			b = xs();
			sh[r] = b[7:0];
			bus(1'b0, 4'(r * 4), sh[r], 1'b1, 8'h00);
			bus(1'b0, 4'(r * 4), ~sh[r], 1'b0, 8'h00);
			bus(1'b1, 4'(r * 4), 8'h00, 1'b1, sh[r]);
		end
		bus(1'b1, 4'h2, 8'h00, 1'b1, 8'h00);
		for (int u = 0; u < 5; u++) begin
			for (int c = 0; c < 8; c++) begin
				// init bit alternates so a stale initial level shows
				cd = {1'b0, c[0], c[2], c[1]};
				set_code(u, cd);
				repeat (2) @(posedge mclk);
				#1;
				chk(pin_oe_n[u], cd[1:0] == 2'h0);
				if (cd[1:0] != 2'h0) chk(pin_out[u], cd[2]);
				for (int k = 0; k < 4 && cd[1:0] != 2'h0; k++) begin
					@(posedge mclk);
					cmp_match <= (k < 3) ? 5'(1 << u) : 5'h00;
					ex = (cd[1:0] == 2'h1) ? 1'b0
						: (cd[1:0] == 2'h2) | (cd[2] ^ k[0]);
					#1 if (k > 0) chk(pin_out[u], ex);
				end
			end
		end
		for (int u = 0; u < 5; u++) begin
			set_code(u, 4'h0);
			repeat (2) @(posedge mclk);
			lv = 1'b0;
			for (int c = 8; c < ((u == 1) ? 16 : 12); c++) begin
				set_code(u, 4'(c));
				for (int k = 0; k < 8; k++) begin
					b = xs();
					@(posedge mclk);
					ext_level[u] <= b[0];
					if ((b[0] & !lv & (c[1] | !c[0])) | (!b[0] & lv & (c[1] | c[0])))
						exp_q.push_back(5'(1 << u));
					lv = b[0];
				end
				repeat (3) @(posedge mclk);
			end
		end
		for (int u = 0; u < 5; u++) if (u != 1) set_code(u, 4'hc);
		repeat (2) @(posedge mclk);
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			ch0_third_event <= (k == 0);
			ch4_count_pulse <= (k != 0);
			ch4_clock_select <= (k == 2) ? 3'h0 : 3'h1;
			buffer_mode_second_pair <= (k == 3);
			ext_level <= ext_level ^ 5'h1d;
			if (k == 0) exp_q.push_back(5'h01);
			if (k == 1) exp_q.push_back(5'h1c);
			if (k == 3) exp_q.push_back(5'h0c);
		end
		@(posedge mclk);
		ch4_count_pulse <= 1'b0;
		set_code(4, 4'h5);
		repeat (2) @(posedge mclk);
		cmp_match <= 5'h10;
		@(posedge mclk);
		cmp_match <= 5'h00;
		repeat (3) @(posedge mclk);
		#1;
		chk(pin_oe_n[4], 1'b1);
		chk(exp_q.size(), 0);
		give_verdict();
	end
endmodule
